// [acc_pkg.sv]
/*
 * acc_pkg: constants and carrier types for the counter array control/status block.
 * Assumes a 32-bit APB with word-aligned registers.
 */
package acc_pkg;

    // ************************************************************
    // register map (byte addresses)
    // ************************************************************
    localparam logic [11:0] ACC_CTRL_OFFS     = 12'h0_0d8;
    localparam logic [11:0] ACC_MODE_OFFS     = 12'h0_0dc;
    localparam logic [11:0] ACC_COUNT_OFFS    = 12'h0_0e0;
    localparam logic [11:0] ACC_IRQ_STAT_OFFS = 12'h0_0e4;
    localparam logic [11:0] ACC_IRQ_EN_OFFS   = 12'h0_0e8;
    localparam logic [11:0] ACC_IRQ_CLR_OFFS  = 12'h0_0ec;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int ACC_OVF_BIT      = 7;
    localparam int ACC_RUN_BIT      = 6;
    localparam int ACC_RSVD_BIT     = 5;
    localparam int ACC_NUM_MODULES  = 5;
    localparam int ACC_OVF_IE_BIT   = 0;
    // interrupt status layout: bits 4..0 module events, bit 5 overflow
    localparam int ACC_IRQ_OVF_BIT  = 5;
    localparam int ACC_IRQ_WIDTH    = 6;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [7:0]  ACC_CTRL_RST  = 8'h00;
    localparam logic [7:0]  ACC_MODE_RST  = 8'h00;
    localparam logic [15:0] ACC_COUNT_RST = 16'h0000;
    localparam logic [5:0]  ACC_IRQ_RST   = 6'h00;

    // ************************************************************
    // carrier types
    // ************************************************************
    typedef struct packed {
        logic [11:0] addr;
        logic        write;
        logic [31:0] wdata;
    } acc_req_type;

    typedef struct packed {
        logic [7:0] high_byte;
        logic [7:0] low_byte;
    } acc_count_type;

endpackage : acc_pkg

// [acc_control_status.sv]
/*
 * acc_control_status: control/status register of the programmable counter array,
 * with the shared 16-bit counter, event flags and interrupt request.
 * Assumes an APB master on pclk, and module match/capture pulses synchronous to pclk.
 */
//
// Behaviour
// - the overflow flag at bit 7 is set when the counter rolls over from its maximum.
// - overflow raises the array interrupt only while the mode overflow enable is one.
// - the overflow flag is set by hardware or a written one, cleared only by a written zero.
// - the counter runs while the run bit at bit 6 is one and stops when it is cleared.
// - module n event flag at bit n is set on its event and stays until software clears it.
// - reserved bit 5 reads as an arbitrary value that nothing may rely on; this block always reads it as zero.
// - the control register sits at 0xd8 and resets with every defined bit zero.
// - the counter is a low byte and a high byte that advances when the low byte overflows.
`timescale 1ns/1ps

module acc_control_status
    import acc_pkg::*;
#(
    parameter int NUM_MODULES = ACC_NUM_MODULES
) (
    // clock and reset
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    input  wire logic                   clk_en,
    // apb slave
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [11:0]            paddr,
    input  wire logic [31:0]            pwdata,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    // counter array side
    input  wire logic                   count_tick,
    input  wire logic [NUM_MODULES-1:0] module_event,
    output logic      [15:0]            counter_value,
    output logic                        counter_run_bit,
    // interrupts
    output logic                        array_irq,
    output logic                        irq
);

    // ************************************************************
    // state
    // ************************************************************
    acc_count_type          count_ff, nxt_count;
    logic                   ovf_ff, nxt_ovf;
    logic                   run_ff, nxt_run;
    logic [NUM_MODULES-1:0] evt_ff, nxt_evt;
    logic [7:0]             mode_ff, nxt_mode;
    logic [ACC_IRQ_WIDTH-1:0] stat_ff, nxt_stat;
    logic [ACC_IRQ_WIDTH-1:0] ien_ff, nxt_ien;
    logic [31:0]            rdata_ff, nxt_rdata;
    logic                   err_ff, nxt_err;

    acc_req_type req;
    logic        setup;
    logic        wr;
    logic        rollover;
    logic        low_wrap;
    logic [ACC_IRQ_WIDTH-1:0] irq_events;

    // exact address match, used for both read and write decode
    function automatic logic hit(input logic [11:0] a, input logic [11:0] offs);
        hit = (a == offs);
    endfunction

    assign req      = '{addr: paddr, write: pwrite, wdata: pwdata};
    // answer in the access cycle: no wait states
    assign setup    = psel & ~penable;
    assign wr       = psel & penable & req.write & clk_en;
    assign pready   = 1'b1;
    assign pslverr  = err_ff & psel & penable;
    assign prdata   = rdata_ff;

    assign low_wrap = (count_ff.low_byte == 8'hff);
    assign rollover = run_ff & count_tick & low_wrap & (count_ff.high_byte == 8'hff);

    assign irq_events = {rollover, module_event};

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        nxt_count = count_ff;
        nxt_ovf   = ovf_ff;
        nxt_run   = run_ff;
        nxt_evt   = evt_ff;
        nxt_mode  = mode_ff;
        nxt_stat  = stat_ff;
        nxt_ien   = ien_ff;
        nxt_rdata = rdata_ff;
        nxt_err   = err_ff;

        if (run_ff && count_tick) begin
            nxt_count.low_byte = count_ff.low_byte + 8'h01;
            if (low_wrap) begin
                nxt_count.high_byte = count_ff.high_byte + 8'h01;
            end
        end

        if (wr) begin
            if (hit(req.addr, ACC_CTRL_OFFS)) begin
                nxt_ovf = req.wdata[ACC_OVF_BIT];
                nxt_run = req.wdata[ACC_RUN_BIT];
                nxt_evt = req.wdata[NUM_MODULES-1:0];
            end else if (hit(req.addr, ACC_MODE_OFFS)) begin
                nxt_mode = req.wdata[7:0];
            end else if (hit(req.addr, ACC_COUNT_OFFS)) begin
                nxt_count = req.wdata[15:0];
            end else if (hit(req.addr, ACC_IRQ_EN_OFFS)) begin
                nxt_ien = req.wdata[ACC_IRQ_WIDTH-1:0];
            end else if (hit(req.addr, ACC_IRQ_CLR_OFFS)) begin
                nxt_stat = stat_ff & ~req.wdata[ACC_IRQ_WIDTH-1:0];
            end
        end

        // hardware set wins over a same-cycle software clear
        // overflow set
        if (rollover) begin
            nxt_ovf = 1'b1;
        end
        nxt_evt  = nxt_evt | module_event;
        nxt_stat = nxt_stat | irq_events;

        if (setup) begin
            nxt_err   = 1'b0;
            nxt_rdata = 32'h0000_0000;
            if (hit(req.addr, ACC_CTRL_OFFS)) begin
                nxt_rdata[ACC_OVF_BIT]         = ovf_ff;
                nxt_rdata[ACC_RUN_BIT]         = run_ff;
                nxt_rdata[ACC_RSVD_BIT]        = 1'b0;
                nxt_rdata[NUM_MODULES-1:0]     = evt_ff;
            end else if (hit(req.addr, ACC_MODE_OFFS)) begin
                nxt_rdata[7:0] = mode_ff;
            end else if (hit(req.addr, ACC_COUNT_OFFS)) begin
                nxt_rdata[15:0] = count_ff;
            end else if (hit(req.addr, ACC_IRQ_STAT_OFFS)) begin
                nxt_rdata[ACC_IRQ_WIDTH-1:0] = stat_ff;
            end else if (hit(req.addr, ACC_IRQ_EN_OFFS)) begin
                nxt_rdata[ACC_IRQ_WIDTH-1:0] = ien_ff;
            end else if (hit(req.addr, ACC_IRQ_CLR_OFFS)) begin
                nxt_rdata = 32'h0000_0000;
            end else begin
                // unmapped address answers with an error
                nxt_err = 1'b1;
            end
        end
    end

    // ************************************************************
    // registers
    // ************************************************************
    // all defined bits reset to zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_ff <= ACC_COUNT_RST;
            ovf_ff   <= ACC_CTRL_RST[ACC_OVF_BIT];
            run_ff   <= ACC_CTRL_RST[ACC_RUN_BIT];
            evt_ff   <= ACC_CTRL_RST[NUM_MODULES-1:0];
            mode_ff  <= ACC_MODE_RST;
            stat_ff  <= ACC_IRQ_RST;
            ien_ff   <= ACC_IRQ_RST;
            rdata_ff <= 32'h0000_0000;
            err_ff   <= 1'b0;
        end else if (clk_en) begin
            count_ff <= nxt_count;
            ovf_ff   <= nxt_ovf;
            run_ff   <= nxt_run;
            evt_ff   <= nxt_evt;
            mode_ff  <= nxt_mode;
            stat_ff  <= nxt_stat;
            ien_ff   <= nxt_ien;
            rdata_ff <= nxt_rdata;
            err_ff   <= nxt_err;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign counter_value   = count_ff;
    assign counter_run_bit = run_ff;
    assign array_irq = ovf_ff & mode_ff[ACC_OVF_IE_BIT];
    assign irq       = |(stat_ff & ien_ff);

endmodule // acc_control_status

// [acc_control_status_properties.sv]
/* checker for acc_control_status: port-level timing of counter, apb and irqs.
   assumes the design ports only; bound into every instance below. */
`timescale 1ns/1ps
module acc_props
    import acc_pkg::*;
#(
    parameter int NUM_MODULES = ACC_NUM_MODULES
) (
    // clock, reset
    input wire logic                   pclk,
    input wire logic                   presetn,
    input wire logic                   clk_en,
    // apb
    input wire logic                   psel,
    input wire logic                   penable,
    input wire logic                   pwrite,
    input wire logic [11:0]            paddr,
    input wire logic [31:0]            pwdata,
    input wire logic [31:0]            prdata,
    input wire logic                   pready,
    input wire logic                   pslverr,
    // counter side, irqs
    input wire logic                   count_tick,
    input wire logic [NUM_MODULES-1:0] module_event,
    input wire logic [15:0]            counter_value,
    input wire logic                   counter_run_bit,
    input wire logic                   array_irq,
    input wire logic                   irq
);
    logic acc, wr, cnt_wr;
    assign acc    = psel && penable && clk_en;
    assign wr     = acc && pwrite;
    assign cnt_wr = wr && paddr == ACC_COUNT_OFFS;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ****************
    // properties
    // ****************
    sequence s_step;
        clk_en && counter_run_bit && count_tick && !cnt_wr;
    endsequence
    a_count_step: assert property (s_step |=> counter_value == $past(counter_value) + 16'h0001)
        else $error("counter did not step");
    a_wrap_zero: assert property (s_step ##0 counter_value == 16'hffff |=> counter_value == 16'h0000)
        else $error("counter did not wrap");
    a_hold_stop: assert property (!(clk_en && counter_run_bit && count_tick) && !cnt_wr |=> $stable(counter_value))
        else $error("counter moved while stopped");
    a_run_write: assert property (wr && paddr == ACC_CTRL_OFFS |=> counter_run_bit == $past(pwdata[ACC_RUN_BIT]))
        else $error("run bit not written");
    a_run_read: assert property (acc && !pwrite && paddr == ACC_CTRL_OFFS |-> prdata[ACC_RUN_BIT] == counter_run_bit)
        else $error("run bit read mismatch");
    a_irq_gate: assert property (wr && paddr == ACC_MODE_OFFS && !pwdata[ACC_OVF_IE_BIT] |=> !array_irq)
        else $error("array irq without enable");
    a_irq_mask: assert property (wr && paddr == ACC_IRQ_EN_OFFS && pwdata[5:0] == 6'h00 |=> !irq)
        else $error("irq high while all masked");
    a_bad_addr: assert property (acc && !(paddr inside {[ACC_CTRL_OFFS:ACC_IRQ_CLR_OFFS]}) |-> pslverr && prdata == 32'h0000_0000)
        else $error("unmapped access not refused");
    a_ready_high: assert property (pready)
        else $error("pready low");
endmodule // acc_props

bind acc_control_status acc_props #(.NUM_MODULES(NUM_MODULES)) props_u (.*);

// [acc_tb.sv]
/* directed testbench for acc_control_status over apb.
   assumes the checker file is compiled alongside. */
`timescale 1ns/1ps
module testbench
    import acc_pkg::*;
;
    logic        pclk = 0, presetn = 0, clk_en = 1, psel = 0, penable = 0, pwrite = 0;
    logic        count_tick = 0, pready, pslverr, counter_run_bit, array_irq, irq;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rdv;
    logic        errv;
    logic [4:0]  module_event = '0;
    logic [15:0] counter_value;
    int          error_cnt = 0, num_checks = 0;

    initial forever #12.5 pclk = ~pclk;
    acc_control_status #(.NUM_MODULES(5)) dut_u (.*);
    // ****************
    // bus and check tasks
    // ****************
    task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
        psel    <= 1'b1;
        penable <= 1'b0;
        paddr   <= a;
        pwrite  <= w;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdv  = prdata;
        errv = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD at %0t got %h exp %h", $time, g, e);
        end
    endtask
    // reserved bit 5 of control is masked: it reads as zero, but nothing may rely on it
    task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m = '1);
        xfer(a, 1'b0, 32'h0000_0000);
        chk(rdv & m, e);
    endtask
    task automatic tick(input int n);
        count_tick <= 1'b1;
        repeat (n) @(posedge pclk);
        count_tick <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // ****************
    // tests
    // ****************
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(ACC_CTRL_OFFS, 32'h0000_0000, 32'h0000_00df);
        rd(ACC_COUNT_OFFS, 32'h0000_0000);
        rd(12'h0f0, 32'h0000_0000);
        chk(32'(errv), 32'h0000_0001);
        $display("test reset done");
        // every control write below keeps reserved bit 5 at zero
        xfer(ACC_CTRL_OFFS, 1'b1, 32'h0000_0040);
        tick(3);
        rd(ACC_COUNT_OFFS, 32'h0000_0003);
        chk(32'(counter_value), 32'h0000_0003);
        chk(32'(counter_run_bit), 32'h0000_0001);
        xfer(ACC_CTRL_OFFS, 1'b1, 32'h0000_0000);
        chk(32'(counter_run_bit), 32'h0000_0000);
        tick(2);
        rd(ACC_COUNT_OFFS, 32'h0000_0003);
        // clock enable low freezes the counter even while running
        xfer(ACC_CTRL_OFFS, 1'b1, 32'h0000_0040);
        clk_en <= 1'b0;
        tick(2);
        clk_en <= 1'b1;
        chk(32'(counter_value), 32'h0000_0003);
        xfer(ACC_CTRL_OFFS, 1'b1, 32'h0000_0000);
        $display("test run done");
        xfer(ACC_MODE_OFFS, 1'b1, 32'h0000_0001);
        xfer(ACC_COUNT_OFFS, 1'b1, 32'h0000_00ff);
        xfer(ACC_CTRL_OFFS, 1'b1, 32'h0000_0040);
        tick(1);
        rd(ACC_COUNT_OFFS, 32'h0000_0100);
        xfer(ACC_COUNT_OFFS, 1'b1, 32'h0000_ffff);
        tick(1);
        rd(ACC_COUNT_OFFS, 32'h0000_0000);
        repeat (4) @(posedge pclk);
        rd(ACC_CTRL_OFFS, 32'h0000_00c0, 32'h0000_00df);
        chk(32'(array_irq), 32'h0000_0001);
        xfer(ACC_MODE_OFFS, 1'b1, 32'h0000_0000);
        chk(32'(array_irq), 32'h0000_0000);
        xfer(ACC_CTRL_OFFS, 1'b1, 32'h0000_0000);
        rd(ACC_CTRL_OFFS, 32'h0000_0000, 32'h0000_00df);
        xfer(ACC_CTRL_OFFS, 1'b1, 32'h0000_0080);
        rd(ACC_CTRL_OFFS, 32'h0000_0080, 32'h0000_00df);
        xfer(ACC_CTRL_OFFS, 1'b1, 32'h0000_0000);
        $display("test overflow done");
        for (int n = 0; n < 5; n++) begin
            module_event <= 5'h01 << n;
            @(posedge pclk);
            module_event <= 5'h00;
            rd(ACC_CTRL_OFFS, (32'h0000_0002 << n) - 32'h0000_0001, 32'h0000_00df);
        end
        rd(ACC_IRQ_STAT_OFFS, 32'h0000_003f);
        xfer(ACC_IRQ_EN_OFFS, 1'b1, 32'h0000_0001);
        chk(32'(irq), 32'h0000_0001);
        xfer(ACC_IRQ_EN_OFFS, 1'b1, 32'h0000_0000);
        chk(32'(irq), 32'h0000_0000);
        xfer(ACC_IRQ_EN_OFFS, 1'b1, 32'h0000_003f);
        xfer(ACC_IRQ_CLR_OFFS, 1'b1, 32'h0000_003f);
        rd(ACC_IRQ_STAT_OFFS, 32'h0000_0000);
        chk(32'(irq), 32'h0000_0000);
        rd(ACC_CTRL_OFFS, 32'h0000_001f, 32'h0000_00df);
        $display("test events done");
        // second reset, with the counter stopped, returns the control register to zero
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(ACC_CTRL_OFFS, 32'h0000_0000, 32'h0000_00df);
        $display("test second reset done");
        end_of_test();
    end
    // tests need under 150 cycles; this only cuts a hang
    initial begin
        repeat (3000) @(posedge pclk);
        error_cnt++;
        end_of_test();
    end
endmodule // testbench
